// *** oscillator_trim_calibrator.sv ***
// Purpose: measure the oscillator against a reference and trim it
// Assumes: all inputs synchronous to mclk, osc level slower than mclk/2
// Notes:   registers reached over classic wishbone, one ack per access
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "osc_trim_consts.svh"

module oscillator_trim_calibrator #(
  parameter int CNT_W  = 16,
  parameter int OSC_HZ = 64000000,
  parameter int REF_HZ = 1000
) (
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire osc_trim_pkg::wb_req_t wb_req,
  output osc_trim_pkg::wb_rsp_t      wb_rsp,
  input  wire logic                  osc_clk_level,
  input  wire logic                  measure_reference_pin,
  output logic                       divided_clock_output,
  output logic [7:0]                 oscillator_trim_value,
  output osc_trim_pkg::cal_events_t  irq_req
);
  import osc_trim_pkg::*;

  localparam logic [CNT_W-1:0] Z_RST = CNT_W'(OSC_HZ / 64 / REF_HZ);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam int XW = CNT_W + 3;

  logic              ack_q;
  logic [31:0]       rdat_q;
  logic [8:1]        ctrl_q;
  logic [CNT_W-1:0]  expect_q;
  logic [15:0]       percent_q;
  logic [7:0]        trim_q;
  logic [CNT_W-1:0]  result_q;
  logic [2:0]        irq_en_q;
  cal_events_t       sticky_q;
  cal_state_t        state_q;
  logic              running_q;
  logic              osc_prev_q;
  logic [4:0]        osc_cnt_q;
  logic              div_clk_q;
  logic              div_prev_q;
  logic [5:0]        tdiv_cnt_q;
  logic [13:0]       rdiv_cnt_q;
  logic              ref_int_q;
  logic              ref_smp_q;
  logic [1:0]        filt_cnt_q;
  logic              ref_filt_q;
  logic              ref_prev_q;
  logic [CNT_W-1:0]  count_q;
  logic              window_q;
  logic              ovf_hold_q;
  logic [2:0]        idx_q;
  logic [CNT_W+1:0]  sum_q;

  logic              wr_en;
  logic              start_pulse;
  logic              osc_rise;
  logic              tgt_edge;
  logic              ref_level;
  logic              ref_edge;
  logic              meas_done;
  logic              set_done;
  logic              ovf_ev;
  logic [5:0]        tdiv_sel;
  logic [13:0]       rdiv_sel;
  logic [CNT_W+1:0]  sum_full;
  logic [CNT_W-1:0]  avg;
  logic [31:0]       l_prod;
  logic [31:0]       m_prod;
  logic signed [XW-1:0] x_s;
  logic signed [XW-1:0] z_pl;
  logic signed [XW-1:0] z_ml;
  logic signed [XW-1:0] z_pm;
  logic signed [XW-1:0] z_mm;
  cal_state_t        next_state;
  logic signed [3:0] step;
  logic signed [8:0] trim_sum;
  logic [7:0]        trim_next;

  assign wr_en = wb_req.cyc && wb_req.stb && wb_req.we && !ack_q && wb_req.sel[0];
  assign start_pulse = wr_en && wb_req.adr == `ADR_CTRL && wb_req.dat[`CTRL_START];

  // wishbone slave: one wait state, unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req.cyc && wb_req.stb && !ack_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdat_q <= 32'h0000_0000;
    end else begin
      unique case (wb_req.adr)
        `ADR_CTRL:    rdat_q <= {23'h0, ctrl_q, 1'b0};
        `ADR_EXPECT:  rdat_q <= 32'(expect_q);
        `ADR_PERCENT: rdat_q <= {16'h0000, percent_q};
        `ADR_TRIM:    rdat_q <= {24'h00_0000, trim_q};
        `ADR_RESULT:  rdat_q <= 32'(result_q);
        `ADR_STATUS:  rdat_q <= {24'h00_0000, running_q, sticky_q.ovf, sticky_q.err,
                                 sticky_q.done, 1'b0, state_q};
        `ADR_IRQ_EN:  rdat_q <= {29'h0, irq_en_q};
        default:      rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_rsp.ack = ack_q;
  assign wb_rsp.dat = rdat_q;

  // configuration; only the low byte lane select is honoured, and ctrl, expect and percent also take lane one
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctrl_q    <= 8'h00;
      expect_q  <= Z_RST;
      percent_q <= `PERCENT_RST;
      irq_en_q  <= 3'h0;
    end else if (wr_en) begin
      unique case (wb_req.adr)
        `ADR_CTRL:    ctrl_q <= wb_req.dat[8:1];
        `ADR_EXPECT:  expect_q <= wb_req.dat[CNT_W-1:0];
        `ADR_PERCENT: percent_q <= wb_req.dat[15:0];
        `ADR_IRQ_EN:  irq_en_q <= wb_req.dat[2:0];
        default:      ;
      endcase
    end
  end

  // target clock: oscillator divided by 64, then the selectable divider
  assign osc_rise = osc_clk_level && !osc_prev_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      osc_prev_q <= 1'b0;
      osc_cnt_q  <= 5'h00;
      div_clk_q  <= 1'b0;
      div_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_clk_level;
      div_prev_q <= div_clk_q;
      if (osc_rise) begin
        osc_cnt_q <= osc_cnt_q + 5'h01;
        if (osc_cnt_q == `OSC_DIV_HALF) begin
          div_clk_q <= !div_clk_q;
        end
      end
    end
  end

  assign divided_clock_output = div_clk_q;

  always_comb begin
    unique case (ctrl_q[`CTRL_TDIV_HI:`CTRL_TDIV_LO])
      2'h0: tdiv_sel = `TDIV_0;
      2'h1: tdiv_sel = `TDIV_1;
      2'h2: tdiv_sel = `TDIV_2;
      2'h3: tdiv_sel = `TDIV_3;
    endcase
    unique case (ctrl_q[`CTRL_RDIV_HI:`CTRL_RDIV_LO])
      2'h0: rdiv_sel = `RDIV_0;
      2'h1: rdiv_sel = `RDIV_1;
      2'h2: rdiv_sel = `RDIV_2;
      2'h3: rdiv_sel = `RDIV_3;
    endcase
  end

  assign tgt_edge = div_clk_q && !div_prev_q && tdiv_cnt_q == tdiv_sel - 6'h01;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tdiv_cnt_q <= 6'h00;
    end else if (div_clk_q && !div_prev_q) begin
      tdiv_cnt_q <= (tdiv_cnt_q >= tdiv_sel - 6'h01) ? 6'h00 : tdiv_cnt_q + 6'h01;
    end
  end

  // internal reference: mclk toggled every div/2 cycles gives period = div
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdiv_cnt_q <= 14'h0000;
      ref_int_q  <= 1'b0;
    end else if (rdiv_cnt_q >= (rdiv_sel >> 1) - 14'h0001) begin
      rdiv_cnt_q <= 14'h0000;
      ref_int_q  <= !ref_int_q;
    end else begin
      rdiv_cnt_q <= rdiv_cnt_q + 14'h0001;
    end
  end

  // reference path; the filter costs two cycles of latency on the pin
  assign ref_level = ctrl_q[`CTRL_REF_INT] ? ref_int_q : ref_filt_q;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ref_smp_q  <= 1'b0;
      filt_cnt_q <= 2'h0;
      ref_filt_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end else begin
      ref_smp_q  <= measure_reference_pin;
      ref_prev_q <= ref_level;
      if (!ctrl_q[`CTRL_FILT_EN]) begin
        ref_filt_q <= ref_smp_q;
        filt_cnt_q <= 2'h0;
      end else if (ref_smp_q == ref_filt_q) begin
        filt_cnt_q <= 2'h0;
      end else if (filt_cnt_q == `FILT_LEN - 2'h1) begin
        ref_filt_q <= ref_smp_q;
        filt_cnt_q <= 2'h0;
      end else begin
        filt_cnt_q <= filt_cnt_q + 2'h1;
      end
    end
  end

  always_comb begin
    unique case (ctrl_q[`CTRL_EDGE_HI:`CTRL_EDGE_LO])
      `EDGE_RISE: ref_edge = ref_level && !ref_prev_q;
      `EDGE_FALL: ref_edge = !ref_level && ref_prev_q;
      `EDGE_BOTH: ref_edge = ref_level != ref_prev_q;
      default:    ref_edge = 1'b0;
    endcase
  end

  // measurement counter, idle outside a calibration run
  assign meas_done = running_q && window_q && ref_edge;
  assign ovf_ev    = running_q && window_q && tgt_edge && count_q == CNT_MAX && !ovf_hold_q;

  always_ff @(posedge mclk) begin
    if (!rstn || !running_q) begin
      count_q    <= '0;
      window_q   <= 1'b0;
      ovf_hold_q <= 1'b0;
    end else if (ref_edge) begin
      count_q    <= '0;
      window_q   <= 1'b1;
      ovf_hold_q <= 1'b0;
    end else if (window_q && tgt_edge) begin
      if (count_q == CNT_MAX) begin
        ovf_hold_q <= 1'b1;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  // averaging over a set
  assign set_done = meas_done && idx_q == `SET_LAST;
  assign sum_full = sum_q + (CNT_W+2)'(count_q);
  assign avg      = sum_full[CNT_W+1:2];

  always_ff @(posedge mclk) begin
    if (!rstn || start_pulse) begin
      idx_q <= 3'h0;
      sum_q <= '0;
    end else if (meas_done) begin
      if (idx_q == 3'h0) begin
        idx_q <= 3'h1;
      end else if (set_done) begin
        idx_q <= 3'h0;
        sum_q <= '0;
      end else begin
        idx_q <= idx_q + 3'h1;
        sum_q <= sum_full;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      result_q <= '0;
    end else if (set_done) begin
      result_q <= avg;
    end
  end

  // thresholds from the expected count
  assign l_prod = 32'(expect_q) * 32'(percent_q) / `PERCENT_DEN;
  assign m_prod = 32'(expect_q) * `COARSE_NUM / `COARSE_DEN;
  assign x_s  = XW'(avg);
  assign z_pl = XW'(expect_q) + XW'(l_prod[CNT_W-1:0]);
  assign z_ml = XW'(expect_q) - XW'(l_prod[CNT_W-1:0]);
  assign z_pm = XW'(expect_q) + XW'(m_prod[CNT_W-1:0]);
  assign z_mm = XW'(expect_q) - XW'(m_prod[CNT_W-1:0]);

  always_comb begin
    if (x_s > z_pl) begin
      next_state = CAL_ABOVE;
    end else if (x_s < z_ml) begin
      next_state = CAL_BELOW;
    end else begin
      next_state = CAL_WITHIN;
    end
    unique case (next_state)
      CAL_ABOVE:  step = (x_s < z_pm) ? -`STEP_FINE : -`STEP_COARSE;
      CAL_BELOW:  step = (x_s > z_mm) ? `STEP_FINE : `STEP_COARSE;
      default: begin
        // the dead band is judged first, since M may be smaller than L
        if (x_s >= z_ml && x_s <= z_pl) begin
          step = 4'sh0;
        end else if (x_s >= z_pm) begin
          step = -`STEP_COARSE;
        end else if (x_s > z_pl) begin
          step = -`STEP_FINE;
        end else if (x_s < z_mm) begin
          step = `STEP_COARSE;
        end else begin
          step = `STEP_FINE;
        end
      end
    endcase
    trim_sum = $signed({trim_q[7], trim_q}) + 9'(step);
    if (trim_sum > `TRIM_MAX) begin
      trim_next = 8'h7F;
    end else if (trim_sum < `TRIM_MIN) begin
      trim_next = 8'h80;
    end else begin
      trim_next = trim_sum[7:0];
    end
  end

  // controller; stays in within until software starts a new run
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q   <= CAL_STANDBY;
      running_q <= 1'b0;
    end else if (start_pulse) begin
      state_q   <= CAL_START;
      running_q <= 1'b1;
    end else if (set_done) begin
      state_q   <= next_state;
      running_q <= next_state != CAL_WITHIN;
    end
  end

  // hardware adjustment wins over a software write in the same cycle
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      trim_q <= `TRIM_RST;
    end else if (set_done) begin
      trim_q <= trim_next;
    end else if (wr_en && wb_req.adr == `ADR_TRIM) begin
      trim_q <= wb_req.dat[7:0];
    end
  end

  assign oscillator_trim_value = trim_q;

  // sticky events, write one to clear, a new event beats the clear
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sticky_q <= '0;
    end else begin
      if (wr_en && wb_req.adr == `ADR_STATUS) begin
        sticky_q <= sticky_q & ~cal_events_t'({wb_req.dat[`ST_DONE],
                    wb_req.dat[`ST_ERR], wb_req.dat[`ST_OVF]}) | cal_events_t'({set_done,
                    set_done && next_state != CAL_WITHIN, ovf_ev});
      end else begin
        sticky_q <= sticky_q | cal_events_t'({set_done,
                    set_done && next_state != CAL_WITHIN, ovf_ev});
      end
    end
  end

  assign irq_req = sticky_q & cal_events_t'(irq_en_q);
endmodule
`default_nettype wire

// *** osc_trim_consts.svh ***
// Purpose: named constants for the oscillator trim calibrator
// Assumes: included by its bare name
// Notes:   register offsets are byte addresses on a 32-bit wishbone bus
`ifndef OSC_TRIM_CONSTS_SVH
`define OSC_TRIM_CONSTS_SVH

`define ADR_CTRL        8'h00
`define ADR_EXPECT      8'h04
`define ADR_PERCENT     8'h08
`define ADR_TRIM        8'h0C
`define ADR_RESULT      8'h10
`define ADR_STATUS      8'h14
`define ADR_IRQ_EN      8'h18

`define CTRL_START      0
`define CTRL_REF_INT    1
`define CTRL_EDGE_LO    2
`define CTRL_EDGE_HI    3
`define CTRL_FILT_EN    4
`define CTRL_RDIV_LO    5
`define CTRL_RDIV_HI    6
`define CTRL_TDIV_LO    7
`define CTRL_TDIV_HI    8

`define ST_DONE         4
`define ST_ERR          5
`define ST_OVF          6
`define ST_BUSY         7

`define EDGE_RISE       2'h0
`define EDGE_FALL       2'h1
`define EDGE_BOTH       2'h2

`define OSC_DIV_HALF    5'h1F
`define RDIV_0          14'h0020
`define RDIV_1          14'h0080
`define RDIV_2          14'h0400
`define RDIV_3          14'h2000
`define TDIV_0          6'h01
`define TDIV_1          6'h04
`define TDIV_2          6'h08
`define TDIV_3          6'h20

`define PERCENT_RST     16'h000A
`define PERCENT_DEN     32'd10000
`define COARSE_NUM      32'd5
`define COARSE_DEN      32'd1000
`define TRIM_RST        8'h00
`define TRIM_MAX        9'sh07F
`define TRIM_MIN        -9'sh080
`define SET_LAST        3'h4
`define FILT_LEN        2'h3
`define STEP_FINE       4'sh1
`define STEP_COARSE     4'sh5

`endif

// *** osc_trim_pkg.sv ***
// Purpose: types for the oscillator trim calibrator
// Assumes: constants come from osc_trim_consts.svh
// Notes:   bus groups travel as packed structs
package osc_trim_pkg;
  typedef enum logic [2:0] {
    CAL_STANDBY,
    CAL_START,
    CAL_ABOVE,
    CAL_BELOW,
    CAL_WITHIN
  } cal_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic done;
    logic err;
    logic ovf;
  } cal_events_t;
endpackage

// *** osc_trim_chk.sv ***
// Purpose: port checks for the oscillator trim calibrator
// Assumes: one clock, synchronous active-low reset
// Notes:   bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
`include "osc_trim_consts.svh"
module osc_trim_chk (
  input wire logic                      mclk,
  input wire logic                      rstn,
  input wire osc_trim_pkg::wb_req_t     wb_req,
  input wire osc_trim_pkg::wb_rsp_t     wb_rsp,
  input wire logic                      osc_clk_level,
  input wire logic                      measure_reference_pin,
  input wire logic                      divided_clock_output,
  input wire logic [7:0]                oscillator_trim_value,
  input wire osc_trim_pkg::cal_events_t irq_req
);
  import osc_trim_pkg::*;
  logic              req_w, trim_wr, hw_chg, osc_q, ref_q, div_q, first_q;
  logic [7:0]        trim_q, wdat_q;
  logic [5:0]        osc_cnt_q;
  logic [3:0]        ref_cnt_q;
  logic signed [8:0] dlt;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  assign req_w   = wb_req.cyc && wb_req.stb;
  assign trim_wr = req_w && wb_req.we && wb_req.sel[0] && wb_rsp.ack && wb_req.adr == `ADR_TRIM;
  // a software write is already visible when its ack is sampled
  assign hw_chg  = oscillator_trim_value != trim_q && !trim_wr;
  assign dlt     = $signed({oscillator_trim_value[7], oscillator_trim_value})
                 - $signed({trim_q[7], trim_q});
  always_ff @(posedge mclk) begin
    osc_q  <= osc_clk_level;
    ref_q  <= measure_reference_pin;
    div_q  <= divided_clock_output;
    trim_q <= oscillator_trim_value;
    wdat_q <= wb_req.dat[7:0];
  end
  // first window after reset is partial, so it is not judged
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      osc_cnt_q <= 6'h00;
      first_q   <= 1'b0;
    end else if (divided_clock_output != div_q) begin
      osc_cnt_q <= {5'h00, osc_clk_level & ~osc_q};
      first_q   <= 1'b1;
    end else begin
      osc_cnt_q <= osc_cnt_q + {5'h00, osc_clk_level & ~osc_q};
    end
  end
  // reference toggles since the last hardware trim step
  always_ff @(posedge mclk) begin
    if (!rstn || hw_chg) ref_cnt_q <= 4'h0;
    else if (measure_reference_pin != ref_q && ref_cnt_q != 4'hF) ref_cnt_q <= ref_cnt_q + 4'h1;
  end
  property p_ack_after;
    req_w && !wb_rsp.ack |-> ##1 wb_rsp.ack;
  endproperty
  a_ack_after: assert property (p_ack_after) else $error("ack late");
  property p_ack_once;
    wb_rsp.ack |=> !wb_rsp.ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_ack_cause;
    wb_rsp.ack |-> $past(req_w);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_unmapped;
    wb_rsp.ack && !wb_req.we && wb_req.adr > `ADR_IRQ_EN |-> wb_rsp.dat == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_trim_write;
    trim_wr |=> oscillator_trim_value == wdat_q;
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write lost");
  property p_trim_step;
    hw_chg |-> dlt == 9'sh001 || dlt == -9'sh001 || dlt == 9'sh005 || dlt == -9'sh005
      || (oscillator_trim_value == 8'h7F && dlt > 9'sh000 && dlt < 9'sh005)
      || (oscillator_trim_value == 8'h80 && dlt < 9'sh000 && dlt > -9'sh005);
  endproperty
  a_trim_step: assert property (p_trim_step) else $error("illegal trim step");
  property p_no_wrap;
    hw_chg |-> dlt <= 9'sh005 && dlt >= -9'sh005;
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("trim wrapped");
  property p_div_period;
    first_q && $changed(divided_clock_output) |-> osc_cnt_q == 6'h20;
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider half period");
  property p_set_spacing;
    hw_chg |-> ref_cnt_q >= 4'h5;
  endproperty
  a_set_spacing: assert property (p_set_spacing) else $error("trim step too soon");
endmodule
`default_nettype wire

// *** ref_source.sv ***
// Purpose: external reference source on the reference pin
// Assumes: 1ns time unit
// Notes:   scaled period so a set fits a short run; idles low
`timescale 1ns/10ps
`default_nettype none
module ref_source #(
  parameter realtime HALF_NS = 22453.3
) (
  input  wire logic run,
  output logic      ref_level
);
  initial ref_level = 1'b0;
  always begin
    #(HALF_NS);
    if (run) ref_level = ~ref_level;
    else ref_level = 1'b0;
  end
endmodule
`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench for the oscillator trim calibrator
// Assumes: osc period 70 ns, reference about ten target periods
// Notes:   small counts give coarse steps only
`timescale 1ns/10ps
`default_nettype none
`include "osc_trim_consts.svh"
module tb;
  import osc_trim_pkg::*;
  logic        mclk, rstn, osc_clk_level, ref_run, ref_level, divided_clock_output;
  logic [7:0]  oscillator_trim_value;
  wb_req_t     wb_req;
  wb_rsp_t     wb_rsp;
  cal_events_t irq_req;
  logic [31:0] rd;
  int          bad_count, tests_run, n;
  oscillator_trim_calibrator oscillator_trim_calibrator_inst (
    .mclk                  (mclk),
    .rstn                  (rstn),
    .wb_req                (wb_req),
    .wb_rsp                (wb_rsp),
    .osc_clk_level         (osc_clk_level),
    .measure_reference_pin (ref_level),
    .divided_clock_output  (divided_clock_output),
    .oscillator_trim_value (oscillator_trim_value),
    .irq_req               (irq_req)
  );
  ref_source ref_source_inst (.run(ref_run), .ref_level(ref_level));
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  // offset keeps osc edges off the mclk edges
  initial begin
    osc_clk_level = 1'b0;
    #3;
    forever #35 osc_clk_level = ~osc_clk_level;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic we, input logic [3:0] sel,
                     input logic [31:0] d);
    int k;
    @(posedge mclk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: a, dat: d};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 50);
    rd = wb_rsp.dat;
    wb_req <= '0;
    if (wb_rsp.ack !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, 4'hF, d);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 4'hF, 32'h0);
    check(nm, rd, e);
  endtask
  task automatic start_cal(input logic [31:0] ctrl, z, trim, pct);
    wr(`ADR_EXPECT, z);
    wr(`ADR_PERCENT, pct);
    wr(`ADR_TRIM, trim);
    wr(`ADR_IRQ_EN, 32'h7);
    wr(`ADR_CTRL, ctrl);
  endtask
  // polls status; a rising-edge set takes about 13500 cycles, a both-edge set about half that
  task automatic wait_done();
    int i;
    for (i = 0; i < 400; i++) begin
      bus(`ADR_STATUS, 1'b0, 4'hF, 32'h0);
      if (rd[`ST_DONE] === 1'b1) break;
      repeat (100) @(posedge mclk);
    end
    if (i >= 400) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic div_rise();
    logic p;
    p = divided_clock_output;
    for (n = 0; n < 600; n++) begin
      @(posedge mclk);
      if (divided_clock_output === 1'b1 && p === 1'b0) break;
      p = divided_clock_output;
    end
  endtask
  initial begin
    rstn = 1'b0;
    wb_req = '0;
    ref_run = 1'b0;
    bad_count = 0;
    tests_run = 0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rc("expect", `ADR_EXPECT, 32'h0000_03E8);
    rc("percent", `ADR_PERCENT, 32'h0000_000A);
    rc("trim", `ADR_TRIM, 32'h0);
    rc("status", `ADR_STATUS, 32'h0);
    wr(8'h1C, 32'hFFFF_FFFF);
    rc("unmapped", 8'h1C, 32'h0);
    bus(`ADR_TRIM, 1'b1, 4'h0, 32'h55);
    rc("trim_sel", `ADR_TRIM, 32'h0);
    div_rise();
    div_rise();
    check("div_period", 32'(n >= 221 && n <= 225), 32'h1);
    ref_run <= 1'b1;
    // both edges, filter on, L = 1 keeps a count of 5 inside Z = 6
    start_cal(32'h19, 32'h6, 32'h0, 32'h7D0);
    wait_done();
    check("status_within", rd, 32'h14);
    check("trim_within", {24'h0, oscillator_trim_value}, 32'h0);
    rc("result_both", `ADR_RESULT, 32'h5);
    check("irq_done", {29'h0, irq_req}, 32'h4);
    wr(`ADR_STATUS, 32'h10);
    repeat (2) @(posedge mclk);
    check("irq_clear", {29'h0, irq_req}, 32'h0);
    repeat (2300) @(posedge mclk);
    rc("status_idle", `ADR_STATUS, 32'h04);
    check("trim_hold", {24'h0, oscillator_trim_value}, 32'h0);
    // count 10 below Z = 20: coarse raise, then saturation
    start_cal(32'h01, 32'h14, 32'h78, 32'h7D0);
    wait_done();
    check("status_below", rd, 32'hB3);
    check("trim_up", {24'h0, oscillator_trim_value}, 32'h7D);
    wr(`ADR_STATUS, 32'h30);
    wait_done();
    check("trim_max", {24'h0, oscillator_trim_value}, 32'h7F);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    check("trim_rst", {24'h0, oscillator_trim_value}, 32'h0);
    // count 10 above Z = 5: coarse lower, then saturation
    start_cal(32'h01, 32'h5, 32'h86, 32'hA);
    wait_done();
    check("status_above", rd, 32'hB2);
    check("trim_down", {24'h0, oscillator_trim_value}, 32'h81);
    wr(`ADR_STATUS, 32'h30);
    wait_done();
    check("trim_min", {24'h0, oscillator_trim_value}, 32'h80);
    rc("result_rise", `ADR_RESULT, 32'hA);
    print_verdict();
  end
endmodule
bind oscillator_trim_calibrator osc_trim_chk osc_trim_chk_inst (
  .mclk                  (mclk),
  .rstn                  (rstn),
  .wb_req                (wb_req),
  .wb_rsp                (wb_rsp),
  .osc_clk_level         (osc_clk_level),
  .measure_reference_pin (measure_reference_pin),
  .divided_clock_output  (divided_clock_output),
  .oscillator_trim_value (oscillator_trim_value),
  .irq_req               (irq_req)
);
`default_nettype wire
